/* include/ces_map.vh */
`ifndef CES_MAP_VH
`define CES_MAP_VH
`define CES_ADDR_S2_RSP    8'h36
`define CES_ADDR_S2_THR    8'h37
`define CES_ADDR_S2_DIV    8'h38
`define CES_ADDR_S3_CFG    8'h39
`define CES_ADDR_STATUS    8'h3C
`define CES_RST_S2_RSP     8'h09
`define CES_RST_S2_THR     8'h00
`define CES_RST_S2_DIV     8'h04
`define CES_RST_S3_CFG     8'h00
`define CES_CLK_KHZ        125000
`endif

/* src/ces_stage_seq.v */
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "ces_map.vh"
module ces_stage_seq #(
    parameter [7:0]  S2_RSP_INIT = `CES_RST_S2_RSP,
    parameter [7:0]  S2_THR_INIT = `CES_RST_S2_THR,
    parameter [7:0]  S2_DIV_INIT = `CES_RST_S2_DIV,
    parameter [7:0]  S3_CFG_INIT = `CES_RST_S3_CFG,
    parameter [31:0] CYC_PER_MS  = `CES_CLK_KHZ
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        resetn_in,
    // register port
    input  wire [7:0]  addr_in,
    input  wire [7:0]  wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [7:0]  rdata_out,
    // sequencer context
    input  wire        start_in,
    input  wire        legacy_in,
    input  wire        bus_ready_in,
    input  wire        bus_present_in,
    input  wire [3:0]  stage2_trigger_select_in,
    input  wire        stage2_timer_behaviour_in,
    input  wire [2:0]  stage2_timer_value_in,
    input  wire [3:0]  stage3_response_code_in,
    input  wire [3:0]  stage3_compare_level_in,
    // comparator results from the analog front end
    input  wire        pos_above_in,
    input  wire        pos_above_floor_in,
    input  wire        neg_above_in,
    // analog controls
    output reg  [3:0]  compare_level_out,
    output reg         cmp_on_neg_out,
    output reg  [1:0]  pos_mode_out,
    output reg  [1:0]  neg_mode_out,
    output reg         lines_short_out,
    output reg         pos_rst_pd_out,
    output reg         neg_rst_pd_out,
    output reg  [3:0]  magnitude_out,
    output reg  [1:0]  sink_current_out,
    output reg  [2:0]  divider_fraction_out,
    output reg         done_out
);
    // line modes: off, driven voltage, resistor to ground, divider
    localparam [1:0] LM_OFF = 2'h0;
    localparam [1:0] LM_VOLT = 2'h1;
    localparam [1:0] LM_RES = 2'h2;
    localparam [1:0] LM_DIV = 2'h3;
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_WAIT = 3'h1;
    localparam [2:0] ST_DELAY = 3'h2;
    localparam [2:0] ST_HOLD = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;

    // preloaded read-only fields; software writes are ignored
    wire [3:0] stage2_response_code      = S2_RSP_INIT[3:0];
    wire [3:0] stage2_response_magnitude = S2_RSP_INIT[7:4];
    wire [1:0] stage2_sink_current       = S2_THR_INIT[5:4];
    wire [3:0] stage2_compare_level      = S2_THR_INIT[3:0];
    wire [2:0] stage2_divider_fraction   = S2_DIV_INIT[2:0];
    wire [2:0] stage3_trigger_select     = S3_CFG_INIT[2:0];
    wire       stage3_timer_behaviour    = S3_CFG_INIT[6];
    wire [2:0] stage3_timer_value        = S3_CFG_INIT[5:3];

    reg  [2:0]  state_r;
    reg         stage_r;
    reg  [31:0] cnt_r;
    reg  [6:0]  ms_r;
    reg         pos_touched_r;
    reg         neg_touched_r;

    // current step's configuration
    wire [2:0] trig = stage_r ? stage3_trigger_select
                              : stage2_trigger_select_in[2:0];
    wire       tbeh = stage_r ? stage3_timer_behaviour
                              : stage2_timer_behaviour_in;
    wire [2:0] tval = stage_r ? stage3_timer_value : stage2_timer_value_in;
    wire [3:0] rcode = stage_r ? stage3_response_code_in
                               : stage2_response_code;
    wire [3:0] lvl = stage_r ? stage3_compare_level_in
                             : stage2_compare_level;

    // timer value to milliseconds
    reg [6:0] ms_sel;
    always @* begin
        case (tval)
            3'h0: ms_sel = 7'd0;
            3'h1: ms_sel = 7'd1;
            3'h2: ms_sel = 7'd5;
            3'h3: ms_sel = 7'd10;
            3'h4: ms_sel = 7'd20;
            3'h5: ms_sel = 7'd40;
            3'h6: ms_sel = 7'd80;
            default: ms_sel = 7'd100;
        endcase
    end

    // trigger detection; reserved selects never fire
    reg hit;
    always @* begin
        case (trig)
            3'h0: hit = bus_ready_in;
            3'h7: hit = bus_present_in;
            3'h1: hit = pos_above_in;
            3'h6: hit = pos_above_in;
            3'h3: hit = neg_above_in;
            3'h2: hit = ~pos_above_in & pos_above_floor_in;
            default: hit = 1'b0;
        endcase
    end

    // response decode into per-line modes
    reg [1:0] pm_nxt;
    reg [1:0] nm_nxt;
    reg       sh_nxt;
    reg       ppd_nxt;
    reg       npd_nxt;
    always @* begin
        pm_nxt = pos_mode_out;
        nm_nxt = neg_mode_out;
        sh_nxt = lines_short_out;
        ppd_nxt = pos_rst_pd_out;
        npd_nxt = neg_rst_pd_out;
        case (rcode)
            4'h0: begin
                pm_nxt = LM_OFF;
                nm_nxt = LM_OFF;
                sh_nxt = 1'b0;
            end
            4'h1: pm_nxt = LM_VOLT;
            4'h2: nm_nxt = LM_VOLT;
            4'h3: begin
                pm_nxt = LM_VOLT;
                nm_nxt = LM_VOLT;
            end
            4'h4: pm_nxt = LM_RES;
            4'h7: nm_nxt = LM_RES;
            4'hD: begin
                pm_nxt = LM_RES;
                nm_nxt = LM_RES;
            end
            4'h6: pm_nxt = LM_DIV;
            4'h9: nm_nxt = LM_DIV;
            4'hC: begin
                pm_nxt = LM_DIV;
                nm_nxt = LM_DIV;
            end
            4'hA: sh_nxt = 1'b1;
            4'hE, 4'hF: begin
                if (trig == 3'h7) begin
                    ppd_nxt = 1'b0;
                    npd_nxt = 1'b0;
                end
            end
            default: ;
        endcase
        // single-line responses keep the pull-down only if untouched
        if (rcode == 4'h1 || rcode == 4'h4 || rcode == 4'h6) begin
            ppd_nxt = (trig == 3'h0) & ~pos_touched_r;
        end
        if (rcode == 4'h2 || rcode == 4'h7 || rcode == 4'h9) begin
            npd_nxt = (trig == 3'h0) & ~neg_touched_r;
        end
        if (pm_nxt != LM_OFF) begin
            ppd_nxt = ppd_nxt & ~(rcode == 4'h3 || rcode == 4'hD
                                  || rcode == 4'hC);
        end
        if (nm_nxt != LM_OFF) begin
            npd_nxt = npd_nxt & ~(rcode == 4'h3 || rcode == 4'hD
                                  || rcode == 4'hC);
        end
    end

    wire ms_tick = (cnt_r == CYC_PER_MS - 32'd1);
    wire is_div = (rcode == 4'h6) | (rcode == 4'h9) | (rcode == 4'hC);
    wire is_volt = (rcode == 4'h1) | (rcode == 4'h2) | (rcode == 4'h3);

    // applies the decoded response and its analog settings
    task apply;
        begin
            pos_mode_out <= pm_nxt;
            neg_mode_out <= nm_nxt;
            lines_short_out <= sh_nxt;
            pos_rst_pd_out <= ppd_nxt;
            neg_rst_pd_out <= npd_nxt;
            pos_touched_r <= pos_touched_r | (pm_nxt != LM_OFF);
            neg_touched_r <= neg_touched_r | (nm_nxt != LM_OFF);
            if (stage_r == 1'b0) begin
                magnitude_out <= stage2_response_magnitude;
                if (!legacy_in && is_volt
                    && stage2_response_magnitude == 4'h0) begin
                    sink_current_out <= stage2_sink_current;
                end
                if (legacy_in && is_div
                    && stage2_divider_fraction != 3'h7) begin
                    divider_fraction_out <= stage2_divider_fraction;
                end
            end
        end
    endtask

    // sequencer: stage 2 then stage 3, each waits, times, responds
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r <= ST_IDLE;
            stage_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
            ms_r <= 7'h00;
            pos_touched_r <= 1'b0;
            neg_touched_r <= 1'b0;
            compare_level_out <= 4'h0;
            cmp_on_neg_out <= 1'b0;
            pos_mode_out <= LM_OFF;
            neg_mode_out <= LM_OFF;
            lines_short_out <= 1'b0;
            pos_rst_pd_out <= 1'b0;
            neg_rst_pd_out <= 1'b0;
            magnitude_out <= 4'h0;
            sink_current_out <= 2'h0;
            divider_fraction_out <= 3'h0;
            done_out <= 1'b0;
        end else begin
            // level only loaded for line triggers under standard profiles
            if (trig != 3'h0 && trig != 3'h7 && !legacy_in
                && lvl != 4'hF) begin
                compare_level_out <= lvl;
            end
            cmp_on_neg_out <= (trig == 3'h3);
            case (state_r)
                ST_IDLE: begin
                    if (start_in) begin
                        state_r <= ST_WAIT;
                        stage_r <= 1'b0;
                        done_out <= 1'b0;
                        pos_rst_pd_out <= 1'b1;
                        neg_rst_pd_out <= 1'b1;
                        pos_touched_r <= 1'b0;
                        neg_touched_r <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (hit) begin
                        cnt_r <= 32'h0000_0000;
                        ms_r <= ms_sel;
                        if (tbeh) begin
                            apply;
                            state_r <= ST_HOLD;
                        end else begin
                            state_r <= ST_DELAY;
                        end
                    end
                end
                ST_DELAY, ST_HOLD: begin
                    if (ms_r == 7'h00) begin
                        if (state_r == ST_DELAY) begin
                            apply;
                        end else if (!hit && trig != 3'h0
                                     && trig != 3'h7) begin
                            // hold over and trigger gone: withdraw
                            pos_mode_out <= LM_OFF;
                            neg_mode_out <= LM_OFF;
                            lines_short_out <= 1'b0;
                        end
                        state_r <= stage_r ? ST_DONE : ST_WAIT;
                        stage_r <= 1'b1;
                    end else if (ms_tick) begin
                        cnt_r <= 32'h0000_0000;
                        ms_r <= ms_r - 7'd1;
                    end else begin
                        cnt_r <= cnt_r + 32'd1;
                    end
                end
                ST_DONE: begin
                    done_out <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // register reads, one cycle latency; unmapped reads zero
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `CES_ADDR_S2_RSP: rdata_out <= S2_RSP_INIT;
                `CES_ADDR_S2_THR: rdata_out <= {2'b00, S2_THR_INIT[5:0]};
                `CES_ADDR_S2_DIV: rdata_out <= {5'h00, S2_DIV_INIT[2:0]};
                `CES_ADDR_S3_CFG: rdata_out <= {1'b0, S3_CFG_INIT[6:0]};
                `CES_ADDR_STATUS: rdata_out <= {4'h0, done_out, state_r};
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule
`default_nettype wire

/* tb/ces_stage_seq_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module ces_seq_chk #(
    parameter [7:0] S2_RSP_INIT = 8'h09
) (
    input wire       clk_in,
    input wire       resetn_in,
    input wire [7:0] addr_in,
    input wire       rd_in,
    input wire [7:0] rdata_out,
    input wire       start_in,
    input wire       legacy_in,
    input wire [3:0] stage3_response_code_in,
    input wire [3:0] compare_level_out,
    input wire [1:0] pos_mode_out,
    input wire       pos_rst_pd_out,
    input wire       neg_rst_pd_out,
    input wire       lines_short_out,
    input wire [2:0] divider_fraction_out,
    input wire       done_out
);
    // code of each stage; a mode may only appear when a code asks for it
    wire [3:0] s3c = stage3_response_code_in;
    wire [3:0] s2c = S2_RSP_INIT[3:0];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    property p_rd_rsp; rd_in && addr_in == 8'h36 |=> rdata_out == S2_RSP_INIT;
    endproperty
    a_rd_rsp: assert property (p_rd_rsp) else $error("bad read");
    property p_start_pd; start_in |=> pos_rst_pd_out && neg_rst_pd_out;
    endproperty
    a_start_pd: assert property (p_start_pd) else $error("no pd");
    property p_volt; $rose(pos_mode_out == 2'd1) |->
        s3c inside {4'h1, 4'h3} || s2c inside {4'h1, 4'h3}; endproperty
    a_volt: assert property (p_volt) else $error("stray volt");
    property p_res; $rose(pos_mode_out == 2'd2) |->
        s3c inside {4'h4, 4'hD} || s2c inside {4'h4, 4'hD}; endproperty
    a_res: assert property (p_res) else $error("stray res");
    property p_div; $rose(pos_mode_out == 2'd3) |->
        s3c inside {4'h6, 4'hC} || s2c inside {4'h6, 4'hC}; endproperty
    a_div: assert property (p_div) else $error("stray div");
    property p_done; done_out && !start_in |=> done_out;
    endproperty
    a_done: assert property (p_done) else $error("done lost");
    // a reset edge may clear the fields, so look one edge past it
    property p_lvl; $past(legacy_in) && $past(resetn_in) |->
        $stable(compare_level_out); endproperty
    a_lvl: assert property (p_lvl) else $error("level moved");
    property p_frac; !$past(legacy_in) && $past(resetn_in) |->
        $stable(divider_fraction_out); endproperty
    a_frac: assert property (p_frac) else $error("frac moved");
    c_div: cover property ($rose(pos_mode_out == 2'd3));
    c_short: cover property (lines_short_out);
    c_done: cover property ($rose(done_out));
endmodule
`default_nettype wire

/* tb/ces_port_dev.sv */
`timescale 1ns/100ps
`default_nettype none
module ces_port_dev (
    // clock and the level picked by the block
    input  wire logic       clk_in,
    input  wire logic [3:0] level_in,
    input  wire logic       slow_in,
    // line voltages the device presents, in millivolts
    input  var  int         pos_mv_in,
    input  var  int         neg_mv_in,
    // comparator results seen by the block
    output logic            pos_above_out,
    output logic            floor_out,
    output logic            neg_above_out
);
    int         lvl;
    logic [2:0] now_r = 3'h0;
    logic [2:0] old_r = 3'h0;
    // level code to mV; the reserved top code sits out of reach
    always_comb begin
        if (level_in == 4'h3)
            lvl = 300;
        else if (level_in < 4'h5)
            lvl = 400;
        else if (level_in < 4'hA)
            lvl = 100 * level_in;
        else
            lvl = 1400 + 200 * (level_in - 4'hA);
    end
    // one edge to settle, two when slow, like a sluggish handset
    always @(posedge clk_in) begin
        now_r <= {pos_mv_in > lvl, pos_mv_in > 400, neg_mv_in > lvl};
        old_r <= now_r;
    end
    assign {pos_above_out, floor_out, neg_above_out} = slow_in ? old_r : now_r;
endmodule
`default_nettype wire

/* tb/test_charger_emulation_stimulus_steps.sv */
`timescale 1ns/100ps
`default_nettype none
module test_charger_emulation_stimulus_steps;
    logic       clk_in, resetn_in, wr_in, rd_in, start_in, legacy_in;
    logic       bus_ready_in, bus_present_in, stage2_timer_behaviour_in;
    logic       pos_above_in, pos_above_floor_in, neg_above_in;
    logic       lines_short_out, pos_rst_pd_out, neg_rst_pd_out;
    logic       done_out, cmp_on_neg_out, slow;
    logic [7:0] addr_in, wdata_in, rdata_out;
    logic [3:0] stage2_trigger_select_in, stage3_response_code_in;
    logic [3:0] stage3_compare_level_in, compare_level_out, magnitude_out;
    logic [2:0] stage2_timer_value_in, divider_fraction_out;
    logic [1:0] pos_mode_out, neg_mode_out, sink_current_out;
    int         pos_mv, neg_mv, error_cnt, samples_checked, cyc, n;
    // {short, pos mode, neg mode} once stage 3 ran; stage 2 is neg divider
    localparam logic [4:0] EXP [16] = '{5'h00, 5'h07, 5'h01, 5'h05, 5'h0B,
        5'h03, 5'h0F, 5'h02, 5'h03, 5'h03, 5'h13, 5'h03, 5'h0F, 5'h0A,
        5'h03, 5'h03};
    // stimulus {ready, present, pos, neg} that fires trigger codes 0, 1, 3, 6 and 7; 0 for the rest
    localparam logic [3:0] HIT [8] = '{8, 2, 0, 1, 0, 0, 2, 4};
    localparam int MS [8] = '{0, 1, 5, 10, 20, 40, 80, 100};
    ces_stage_seq #(.CYC_PER_MS(4)) dut (.*);
    ces_port_dev dev (.clk_in, .level_in(compare_level_out), .slow_in(slow),
        .pos_mv_in(pos_mv), .neg_mv_in(neg_mv), .pos_above_out(pos_above_in),
        .floor_out(pos_above_floor_in), .neg_above_out(neg_above_in));
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one read strobe, data looked at in the following cycle only
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk("rdata", exp, rdata_out);
    endtask
    task automatic set(logic [3:0] v);
        @(posedge clk_in);
        {bus_ready_in, bus_present_in} <= v[3:2];
        pos_mv <= v[1] ? 600 : 0;
        neg_mv <= v[0] ? 600 : 0;
    endtask
    // fresh reset, fields loaded, sequence started with nothing present
    task automatic go(logic [2:0] tr, logic ty, logic [2:0] td,
                      logic [3:0] c3, logic lg);
        set(4'h0);
        resetn_in <= 1'b0;
        stage2_trigger_select_in <= {1'b0, tr};
        stage2_timer_behaviour_in <= ty;
        stage2_timer_value_in <= td;
        stage3_response_code_in <= c3;
        legacy_in <= lg;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        start_in <= 1'b1;
        @(posedge clk_in);
        start_in <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    // counts cycles until the stage 2 divider shows; bounded
    task automatic wt(output int k);
        k = 0;
        while (neg_mode_out !== 2'd3 && k < 900) begin
            @(posedge clk_in);
            #1 k++;
        end
    endtask
    initial begin
        clk_in = 0;
        forever #4 clk_in = ~clk_in;
    end
    // hang guard: well above the roughly 1800 cycles the tests need
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        {resetn_in, wr_in, rd_in, start_in, legacy_in, slow} = 6'h00;
        {bus_ready_in, bus_present_in, stage2_timer_behaviour_in} = 3'h0;
        {addr_in, wdata_in, stage2_trigger_select_in} = 20'h0;
        {stage3_response_code_in, stage3_compare_level_in} = 8'h05;
        stage2_timer_value_in = 3'h0;
        pos_mv = 0;
        neg_mv = 0;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(8'h36, 8'h09);
        rd(8'h37, 8'h00);
        rd(8'h38, 8'h04);
        rd(8'h39, 8'h00);
        rd(8'h50, 8'h00);
        @(posedge clk_in);
        {wr_in, addr_in, wdata_in} <= {1'b1, 8'h36, 8'hFF};
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd(8'h36, 8'h09);
        // wrong stimulus must not fire; the right one must
        for (int t = 0; t < 8; t++) begin
            go(t[2:0], 1'b0, 3'h0, 4'h5, 1'b0);
            set(~HIT[t]);
            repeat (25) @(posedge clk_in);
            #1 chk("idle", 0, neg_mode_out);
            chk("cmp_neg", t == 3, cmp_on_neg_out);
            if (HIT[t] != 0) begin
                set(HIT[t]);
                wt(n);
                chk("fire", 3, neg_mode_out);
            end
        end
        for (int t = 0; t < 8; t++) begin
            slow <= t[0];
            go(3'h1, 1'b0, t[2:0], 4'h5, 1'b0);
            set(4'h2);
            wt(n);
            chk("delay", 1, n >= MS[t] * 4 && n <= MS[t] * 4 + 6);
        end
        // hold type: on at once, kept 10 ms, gone only if stimulus went
        for (int k = 0; k < 2; k++) begin
            go(3'h1, 1'b1, 3'h3, 4'h5, 1'b0);
            set(4'h2);
            wt(n);
            chk("hold", 1, n <= 4);
            if (k == 0)
                set(4'h0);
            repeat (30) @(posedge clk_in);
            #1 chk("held", 3, neg_mode_out);
            repeat (20) @(posedge clk_in);
            #1 chk("after", k ? 3 : 0, neg_mode_out);
        end
        for (int c = 0; c < 16; c++) begin
            go(3'h1, 1'b0, 3'h0, c[3:0], c == 5);
            set(4'hA);
            for (n = 0; n < 60 && done_out !== 1'b1; n++)
                @(posedge clk_in);
            #1 chk("modes", EXP[c], {lines_short_out, pos_mode_out,
                neg_mode_out});
            chk("frac", c == 5 ? 4 : 0, divider_fraction_out);
            chk("npd", 0, neg_rst_pd_out);
            chk("sink", 0, sink_current_out);
            chk("mag", 0, magnitude_out);
            chk("level", 0, compare_level_out);
            if (c inside {1, 4, 6, 14, 15})
                chk("pd", 1, pos_rst_pd_out);
        end
        results();
    end
endmodule
bind ces_stage_seq ces_seq_chk #(.S2_RSP_INIT(S2_RSP_INIT)) chk_i (.*);
`default_nettype wire
